// ==== design/synth_cfg_pkg.sv ====
package synth_cfg_pkg;

    // Configuration port offsets, as printed for the configuration port
    localparam logic [7:0] OFS_MAIN  = 8'h00;
    localparam logic [7:0] OFS_B1_R  = 8'h06;
    localparam logic [7:0] OFS_B1_P  = 8'h07;
    localparam logic [7:0] OFS_B1_S  = 8'h08;
    localparam logic [7:0] OFS_B2_R  = 8'h09;
    localparam logic [7:0] OFS_B2_P  = 8'h0a;
    localparam logic [7:0] OFS_B2_S  = 8'h0b;
    localparam logic [7:0] OFS_RAMP  = 8'h0c;

    // Slot order of the six divider registers inside the bank store
    localparam logic [2:0] SLOT_B1_R = 3'h0;
    localparam logic [2:0] SLOT_B1_P = 3'h1;
    localparam logic [2:0] SLOT_B1_S = 3'h2;
    localparam logic [2:0] SLOT_B2_R = 3'h3;
    localparam logic [2:0] SLOT_B2_P = 3'h4;
    localparam logic [2:0] SLOT_B2_S = 3'h5;
    localparam logic [2:0] SLOT_NONE = 3'h7;

    // Field positions
    localparam int BANK_SEL_BIT = 0;
    localparam int BAND_LSB     = 3;
    localparam int RAMP_LSB     = 3;

    // Values after reset
    localparam logic [7:0] MAIN_RESET = 8'h00;
    localparam logic [7:0] RAMP_RESET = 8'h00;
    localparam logic [7:0] DIV_RESET  = 8'h00;

    // Band codes
    typedef enum logic [1:0] {
        BAND_902_915 = 2'h0,
        BAND_915_928 = 2'h1,
        BAND_LOW_HIGH = 2'h2,
        BAND_UNUSED  = 2'h3
    } band_t;

    // Regulator rise/fall time per ramp code, in tenths of a microsecond
    localparam logic [7:0] RAMP_TIME_0 = 8'h1e;
    localparam logic [7:0] RAMP_TIME_1 = 8'h55;
    localparam logic [7:0] RAMP_TIME_2 = 8'h96;
    localparam logic [7:0] RAMP_TIME_3 = 8'he6;

    // Loop divider: numerator 75*(P+1)+S, reference divider R+1
    localparam logic [15:0] LOOP_MULT = 16'h004b;

endpackage

// ==== design/synth_bank_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface synth_bank_if;
    logic [7:0] b1_r;
    logic [7:0] b1_p;
    logic [7:0] b1_s;
    logic [7:0] b2_r;
    logic [7:0] b2_p;
    logic [7:0] b2_s;
    logic       sel;

    modport cfg (output b1_r, b1_p, b1_s, b2_r, b2_p, b2_s, sel);
    modport use_side (input b1_r, b1_p, b1_s, b2_r, b2_p, b2_s, sel);
endinterface
`default_nettype wire

// ==== design/synth_bank_select.sv ====
`timescale 1ns/100ps
`default_nettype none
module synth_bank_select (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    // Both banks and the select bit
    synth_bank_if.use_side   bank,
    // Active divider set
    output logic             bank_out,
    output logic [7:0]       r_out,
    output logic [7:0]       p_out,
    output logic [7:0]       s_out,
    output logic [15:0]      loop_num_out,
    output logic [8:0]       ref_div_out
);
    typedef struct packed {
        logic        bank;
        logic [7:0]  r;
        logic [7:0]  p;
        logic [7:0]  s;
        logic [15:0] num;
        logic [8:0]  den;
    } sel_state_t;

    sel_state_t st;
    sel_state_t next_st;

    always_comb begin
        logic [7:0] r;
        logic [7:0] p;
        logic [7:0] s;
        r = bank.sel ? bank.b2_r : bank.b1_r;
        p = bank.sel ? bank.b2_p : bank.b1_p;
        s = bank.sel ? bank.b2_s : bank.b1_s;
        next_st      = st;
        next_st.bank = bank.sel;
        next_st.r    = r;
        next_st.p    = p;
        next_st.s    = s;
        // 16 bits hold the largest numerator, 75*256+255
        next_st.num  = 16'(synth_cfg_pkg::LOOP_MULT * ({8'h00, p} + 16'h0001) + {8'h00, s});
        next_st.den  = {1'b0, r} + 9'h001;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st <= '0;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    assign bank_out     = st.bank;
    assign r_out        = st.r;
    assign p_out        = st.p;
    assign s_out        = st.s;
    assign loop_num_out = st.num;
    assign ref_div_out  = st.den;

    property p_num_formula;
        @(posedge clk_in) disable iff (rst_in)
        ce_in |=> loop_num_out == 16'(16'd75 * ({8'h00, $past(bank.sel ? bank.b2_p : bank.b1_p)} + 16'd1)
                                      + {8'h00, $past(bank.sel ? bank.b2_s : bank.b1_s)})
            && ref_div_out == {1'b0, $past(bank.sel ? bank.b2_r : bank.b1_r)} + 9'd1;
    endproperty
    a_num_formula: assert property (p_num_formula) else $error("loop divider does not match P, S and R");

    property p_inactive_write;
        @(posedge clk_in) disable iff (rst_in)
        // A frozen cycle before lets the outputs catch up later, so it is excluded
        ce_in && $past(ce_in) && !bank.sel && $stable(bank.sel)
            && $stable(bank.b1_r) && $stable(bank.b1_p) && $stable(bank.b1_s)
        |=> $stable(r_out) && $stable(p_out) && $stable(s_out);
    endproperty
    a_inactive_write: assert property (p_inactive_write) else $error("inactive bank write moved the active set");
endmodule // synth_bank_select
`default_nettype wire

// ==== design/synth_channel_bank_select.sv ====
`timescale 1ns/100ps
`default_nettype none
module synth_channel_bank_select #(
    parameter int CFG_ADDR_W = 5
) (
    // Clock, reset, enable
    input  wire logic                  CLK_IN,
    input  wire logic                  RST_IN,
    input  wire logic                  CE_IN,
    // Configuration port
    input  wire logic                  CFG_WR_IN,
    input  wire logic                  CFG_RD_IN,
    input  wire logic [CFG_ADDR_W-1:0] CFG_ADDR_IN,
    input  wire logic [7:0]            CFG_WDATA_IN,
    output logic      [7:0]            CFG_RDATA_OUT,
    output logic                       CFG_RVALID_OUT,
    // Synthesizer control
    output logic                       ACTIVE_BANK_OUT,
    output logic      [7:0]            DIV_R_OUT,
    output logic      [7:0]            DIV_P_OUT,
    output logic      [7:0]            DIV_S_OUT,
    output logic      [15:0]           LOOP_NUM_OUT,
    output logic      [8:0]            REF_DIV_OUT,
    // Band selection
    output logic      [1:0]            BAND_OUT,
    output logic                       BAND_863_870_OUT,
    output logic                       BAND_902_915_OUT,
    output logic                       BAND_915_928_OUT,
    output logic                       BAND_950_960_OUT,
    output logic                       BAND_VALID_OUT,
    // Power amplifier regulator ramp
    output logic      [1:0]            PA_RAMP_CODE_OUT,
    output logic      [7:0]            PA_RAMP_TIME_OUT
);
    // Offsets reach 0x0c and are compared on eight bits
    if (CFG_ADDR_W < 4 || CFG_ADDR_W > 8) begin : g_bad_addr_w
        $error("CFG_ADDR_W must lie in 4..8");
    end

    typedef struct packed {
        logic [7:0]      main;
        logic [7:0]      ramp;
        logic [5:0][7:0] divs;
        logic [7:0]      rdata;
        logic            rvalid;
        logic [1:0]      band;
        logic [3:0]      band_hit;
        logic            band_valid;
        logic [1:0]      ramp_code;
        logic [7:0]      ramp_time;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    // Shared by the write and the read decode
    function automatic logic [2:0] div_slot(input logic [7:0] ofs);
        unique case (ofs)
            synth_cfg_pkg::OFS_B1_R: div_slot = synth_cfg_pkg::SLOT_B1_R;
            synth_cfg_pkg::OFS_B1_P: div_slot = synth_cfg_pkg::SLOT_B1_P;
            synth_cfg_pkg::OFS_B1_S: div_slot = synth_cfg_pkg::SLOT_B1_S;
            synth_cfg_pkg::OFS_B2_R: div_slot = synth_cfg_pkg::SLOT_B2_R;
            synth_cfg_pkg::OFS_B2_P: div_slot = synth_cfg_pkg::SLOT_B2_P;
            synth_cfg_pkg::OFS_B2_S: div_slot = synth_cfg_pkg::SLOT_B2_S;
            default:                 div_slot = synth_cfg_pkg::SLOT_NONE;
        endcase
    endfunction

    function automatic logic [7:0] ramp_time(input logic [1:0] code);
        unique case (code)
            2'h0: ramp_time = synth_cfg_pkg::RAMP_TIME_0;
            2'h1: ramp_time = synth_cfg_pkg::RAMP_TIME_1;
            2'h2: ramp_time = synth_cfg_pkg::RAMP_TIME_2;
            2'h3: ramp_time = synth_cfg_pkg::RAMP_TIME_3;
        endcase
    endfunction

    logic [7:0] addr;
    logic [2:0] wslot;
    assign addr  = 8'(CFG_ADDR_IN);
    assign wslot = div_slot(addr);

    always_comb begin
        logic [1:0] band;
        logic [1:0] rcode;
        band           = st.main[synth_cfg_pkg::BAND_LSB +: 2];
        rcode          = st.ramp[synth_cfg_pkg::RAMP_LSB +: 2];
        next_st        = st;
        next_st.rvalid = 1'b0;
        // Writes: unmapped offsets are dropped without effect
        if (CFG_WR_IN) begin
            if (wslot != synth_cfg_pkg::SLOT_NONE) begin
                next_st.divs[wslot] = CFG_WDATA_IN;
            end else if (addr == synth_cfg_pkg::OFS_MAIN) begin
                next_st.main = CFG_WDATA_IN;
            end else if (addr == synth_cfg_pkg::OFS_RAMP) begin
                next_st.ramp = CFG_WDATA_IN;
            end
        end
        // Reads return the value before a same-cycle write; unmapped read as zero
        if (CFG_RD_IN) begin
            next_st.rvalid = 1'b1;
            if (wslot != synth_cfg_pkg::SLOT_NONE) begin
                next_st.rdata = st.divs[wslot];
            end else if (addr == synth_cfg_pkg::OFS_MAIN) begin
                next_st.rdata = st.main;
            end else if (addr == synth_cfg_pkg::OFS_RAMP) begin
                next_st.rdata = st.ramp;
            end else begin
                next_st.rdata = 8'h00;
            end
        end
        next_st.band       = band;
        next_st.band_hit   = 4'h0;
        next_st.band_valid = 1'b1;
        unique case (band)
            synth_cfg_pkg::BAND_902_915:  next_st.band_hit = 4'h2;
            synth_cfg_pkg::BAND_915_928:  next_st.band_hit = 4'h4;
            synth_cfg_pkg::BAND_LOW_HIGH: next_st.band_hit = 4'h9;
            synth_cfg_pkg::BAND_UNUSED:   next_st.band_valid = 1'b0;
        endcase
        next_st.ramp_code = rcode;
        next_st.ramp_time = ramp_time(rcode);
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            st            <= '0;
            st.main       <= synth_cfg_pkg::MAIN_RESET;
            st.ramp       <= synth_cfg_pkg::RAMP_RESET;
            st.divs       <= {6{synth_cfg_pkg::DIV_RESET}};
            st.band_hit   <= 4'h2;
            st.band_valid <= 1'b1;
            st.ramp_time  <= synth_cfg_pkg::RAMP_TIME_0;
        end else if (CE_IN) begin
            st <= next_st;
        end
    end

    // The select bit reaches the bank mux only through the register copy, so the
    // host's write order alone decides when a bank goes live
    synth_bank_if bank_bus ();
    assign bank_bus.b1_r = st.divs[synth_cfg_pkg::SLOT_B1_R];
    assign bank_bus.b1_p = st.divs[synth_cfg_pkg::SLOT_B1_P];
    assign bank_bus.b1_s = st.divs[synth_cfg_pkg::SLOT_B1_S];
    assign bank_bus.b2_r = st.divs[synth_cfg_pkg::SLOT_B2_R];
    assign bank_bus.b2_p = st.divs[synth_cfg_pkg::SLOT_B2_P];
    assign bank_bus.b2_s = st.divs[synth_cfg_pkg::SLOT_B2_S];
    assign bank_bus.sel  = st.main[synth_cfg_pkg::BANK_SEL_BIT];

    synth_bank_select u_select (
        .clk_in       (CLK_IN),
        .rst_in       (RST_IN),
        .ce_in        (CE_IN),
        .bank         (bank_bus),
        .bank_out     (ACTIVE_BANK_OUT),
        .r_out        (DIV_R_OUT),
        .p_out        (DIV_P_OUT),
        .s_out        (DIV_S_OUT),
        .loop_num_out (LOOP_NUM_OUT),
        .ref_div_out  (REF_DIV_OUT)
    );

    assign CFG_RDATA_OUT    = st.rdata;
    assign CFG_RVALID_OUT   = st.rvalid;
    assign BAND_OUT         = st.band;
    assign BAND_863_870_OUT = st.band_hit[0];
    assign BAND_902_915_OUT = st.band_hit[1];
    assign BAND_915_928_OUT = st.band_hit[2];
    assign BAND_950_960_OUT = st.band_hit[3];
    assign BAND_VALID_OUT   = st.band_valid;
    assign PA_RAMP_CODE_OUT = st.ramp_code;
    assign PA_RAMP_TIME_OUT = st.ramp_time;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    property p_bank_select;
        CE_IN |=> ACTIVE_BANK_OUT == $past(st.main[synth_cfg_pkg::BANK_SEL_BIT])
            && DIV_R_OUT == (ACTIVE_BANK_OUT ? $past(st.divs[synth_cfg_pkg::SLOT_B2_R])
                                             : $past(st.divs[synth_cfg_pkg::SLOT_B1_R]))
            && DIV_P_OUT == (ACTIVE_BANK_OUT ? $past(st.divs[synth_cfg_pkg::SLOT_B2_P])
                                             : $past(st.divs[synth_cfg_pkg::SLOT_B1_P]))
            && DIV_S_OUT == (ACTIVE_BANK_OUT ? $past(st.divs[synth_cfg_pkg::SLOT_B2_S])
                                             : $past(st.divs[synth_cfg_pkg::SLOT_B1_S]));
    endproperty
    a_bank_select: assert property (p_bank_select) else $error("active bank does not follow select bit");

    property p_band_decode;
        CE_IN |=> (BAND_902_915_OUT == ($past(st.main[4:3]) == 2'b00))
            && (BAND_915_928_OUT == ($past(st.main[4:3]) == 2'b01))
            && (BAND_863_870_OUT == ($past(st.main[4:3]) == 2'b10))
            && (BAND_950_960_OUT == BAND_863_870_OUT)
            && (BAND_VALID_OUT == ($past(st.main[4:3]) != 2'b11));
    endproperty
    a_band_decode: assert property (p_band_decode) else $error("band decode wrong");

    property p_ramp_time;
        CE_IN |=> PA_RAMP_CODE_OUT == $past(st.ramp[4:3])
            && (PA_RAMP_CODE_OUT != 2'b11 || PA_RAMP_TIME_OUT == 8'd230)
            && (PA_RAMP_CODE_OUT != 2'b00 || PA_RAMP_TIME_OUT == 8'd30);
    endproperty
    a_ramp_time: assert property (p_ramp_time) else $error("ramp time does not follow ramp code");

    property p_readback;
        CE_IN && CFG_WR_IN && !CFG_RD_IN && addr == 8'h07 ##1 CE_IN && CFG_RD_IN && !CFG_WR_IN && addr == 8'h07
            |=> CFG_RVALID_OUT && CFG_RDATA_OUT == $past(CFG_WDATA_IN, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("divider register did not read back as written");

    property p_inactive_stable;
        CE_IN && CFG_WR_IN && wslot >= 3'h3 && wslot <= 3'h5 && !st.main[0] && !ACTIVE_BANK_OUT
            ##1 CE_IN && !CFG_WR_IN |=> $stable(DIV_R_OUT) && $stable(DIV_P_OUT) && $stable(DIV_S_OUT);
    endproperty
    a_inactive_stable: assert property (p_inactive_stable) else $error("bank two write disturbed bank one");

    property p_loop_live;
        CE_IN && !ACTIVE_BANK_OUT ##1 CE_IN |-> LOOP_NUM_OUT == 16'(16'd75 * ({8'h00, DIV_P_OUT} + 16'd1)
                                                                 + {8'h00, DIV_S_OUT});
    endproperty
    a_loop_live: assert property (p_loop_live) else $error("loop numerator off");

    c_bank_two: cover property (CE_IN && ACTIVE_BANK_OUT ##1 !ACTIVE_BANK_OUT);
    c_band_high: cover property (BAND_950_960_OUT && PA_RAMP_CODE_OUT == 2'b11);
    c_readback: cover property (CFG_WR_IN ##1 CFG_RD_IN ##1 CFG_RVALID_OUT);
endmodule // synth_channel_bank_select
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] %0t mismatch got %h expected %h", $time, (got), (exp)); end end
module testbench;
    logic        clk;
    logic        rst;
    logic        ce;
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        act_bank;
    logic [7:0]  div_r;
    logic [7:0]  div_p;
    logic [7:0]  div_s;
    logic [15:0] loop_num;
    logic [8:0]  ref_div;
    logic [1:0]  band;
    logic        b863;
    logic        b902;
    logic        b915;
    logic        b950;
    logic        band_ok;
    logic [1:0]  ramp_code;
    logic [7:0]  ramp_time;
    int          mismatches;
    int          num_checks;
    logic [7:0]  got;
    logic [7:0]  ramp_tbl [4];

    synth_channel_bank_select #(.CFG_ADDR_W(5)) DUT (
        .CLK_IN           (clk),
        .RST_IN           (rst),
        .CE_IN            (ce),
        .CFG_WR_IN        (wr),
        .CFG_RD_IN        (rd),
        .CFG_ADDR_IN      (addr),
        .CFG_WDATA_IN     (wdata),
        .CFG_RDATA_OUT    (rdata),
        .CFG_RVALID_OUT   (rvalid),
        .ACTIVE_BANK_OUT  (act_bank),
        .DIV_R_OUT        (div_r),
        .DIV_P_OUT        (div_p),
        .DIV_S_OUT        (div_s),
        .LOOP_NUM_OUT     (loop_num),
        .REF_DIV_OUT      (ref_div),
        .BAND_OUT         (band),
        .BAND_863_870_OUT (b863),
        .BAND_902_915_OUT (b902),
        .BAND_915_928_OUT (b915),
        .BAND_950_960_OUT (b950),
        .BAND_VALID_OUT   (band_ok),
        .PA_RAMP_CODE_OUT (ramp_code),
        .PA_RAMP_TIME_OUT (ramp_time)
    );

    always #50 clk = ~clk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One-cycle strobe; the register updates on the rising edge in between
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr    = 1'b1;
        addr  = a[4:0];
        wdata = d;
        @(negedge clk);
        wr    = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk);
        rd   = 1'b1;
        addr = a[4:0];
        @(negedge clk);
        rd   = 1'b0;
        while (rvalid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (n == 4) begin
            mismatches++;
            $display("[ERR] %0t read answer missing", $time);
            tally_and_finish();
        end else begin
            d = rdata;
        end
    endtask

    // Outputs follow the register one edge later, so let one more edge pass
    task automatic chk_div(input logic bk, input logic [7:0] r, input logic [7:0] p, input logic [7:0] s);
        @(negedge clk);
        `CHK(act_bank, bk)
        `CHK(div_r, r)
        `CHK(div_p, p)
        `CHK(div_s, s)
        `CHK(loop_num, 16'(75 * (int'(p) + 1) + int'(s)))
        `CHK(ref_div, 9'(int'(r) + 1))
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 5'h00;
        wdata = 8'h00;
        mismatches = 0;
        num_checks = 0;
        ramp_tbl = '{8'h1e, 8'h55, 8'h96, 8'he6};
        repeat (2) @(negedge clk);
        rst = 1'b0;
        `CHK(b902, 1'b1)
        `CHK(band_ok, 1'b1)
        `CHK(ramp_time, 8'h1e)
        chk_div(1'b0, 8'h00, 8'h00, 8'h00);

        // Load bank one while it is active; top values of the P and S ranges
        wr_reg(synth_cfg_pkg::OFS_B1_R, 8'ha9);
        wr_reg(synth_cfg_pkg::OFS_B1_P, 8'hff);
        wr_reg(synth_cfg_pkg::OFS_B1_S, 8'hff);
        chk_div(1'b0, 8'ha9, 8'hff, 8'hff);
        // Next hop into the inactive bank must leave the running one alone
        wr_reg(synth_cfg_pkg::OFS_B2_R, 8'h77);
        wr_reg(synth_cfg_pkg::OFS_B2_P, 8'h64);
        wr_reg(synth_cfg_pkg::OFS_B2_S, 8'h32);
        chk_div(1'b0, 8'ha9, 8'hff, 8'hff);
        wr_reg(synth_cfg_pkg::OFS_MAIN, 8'h01);
        chk_div(1'b1, 8'h77, 8'h64, 8'h32);
        wr_reg(synth_cfg_pkg::OFS_B1_R, 8'h40);
        wr_reg(synth_cfg_pkg::OFS_B1_P, 8'h00);
        wr_reg(synth_cfg_pkg::OFS_B1_S, 8'h00);
        chk_div(1'b1, 8'h77, 8'h64, 8'h32);
        wr_reg(synth_cfg_pkg::OFS_MAIN, 8'h00);
        chk_div(1'b0, 8'h40, 8'h00, 8'h00);

        // Read back all six divider registers
        rd_reg(synth_cfg_pkg::OFS_B1_R, got);
        `CHK(got, 8'h40)
        rd_reg(synth_cfg_pkg::OFS_B1_P, got);
        `CHK(got, 8'h00)
        rd_reg(synth_cfg_pkg::OFS_B1_S, got);
        `CHK(got, 8'h00)
        rd_reg(synth_cfg_pkg::OFS_B2_R, got);
        `CHK(got, 8'h77)
        rd_reg(synth_cfg_pkg::OFS_B2_P, got);
        `CHK(got, 8'h64)
        rd_reg(synth_cfg_pkg::OFS_B2_S, got);
        `CHK(got, 8'h32)

        // Write and read in one cycle answer with the old value
        @(negedge clk);
        wr = 1'b1;
        rd = 1'b1;
        addr = synth_cfg_pkg::OFS_B2_S[4:0];
        wdata = 8'h5a;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        `CHK(rvalid, 1'b1)
        `CHK(rdata, 8'h32)
        rd_reg(synth_cfg_pkg::OFS_B2_S, got);
        `CHK(got, 8'h5a)

        // Write then read of one divider in back-to-back cycles
        @(negedge clk);
        wr = 1'b1;
        addr = synth_cfg_pkg::OFS_B1_P[4:0];
        wdata = 8'h3c;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        `CHK(rvalid, 1'b1)
        `CHK(rdata, 8'h3c)
        chk_div(1'b0, 8'h40, 8'h3c, 8'h00);

        // Unmapped offsets: write ignored, read answers zero
        wr_reg(8'h05, 8'hc3);
        rd_reg(8'h1f, got);
        `CHK(got, 8'h00)
        rd_reg(synth_cfg_pkg::OFS_B2_R, got);
        `CHK(got, 8'h77)

        // Clock enable low drops the write
        ce = 1'b0;
        wr_reg(synth_cfg_pkg::OFS_B2_R, 8'h99);
        ce = 1'b1;
        rd_reg(synth_cfg_pkg::OFS_B2_R, got);
        `CHK(got, 8'h77)

        // Every band code, with bank two kept selected
        for (int c = 0; c < 4; c++) begin
            wr_reg(synth_cfg_pkg::OFS_MAIN, 8'((c << 3) | 1));
            @(negedge clk);
            `CHK(band, 2'(c))
            `CHK(b902, 1'(c == 0))
            `CHK(b915, 1'(c == 1))
            `CHK(b863, 1'(c == 2))
            `CHK(b950, 1'(c == 2))
            `CHK(band_ok, 1'(c != 3))
            `CHK(act_bank, 1'b1)
        end

        // Every ramp code, shortest to longest
        for (int c = 0; c < 4; c++) begin
            wr_reg(synth_cfg_pkg::OFS_RAMP, 8'(c << 3));
            @(negedge clk);
            `CHK(ramp_code, 2'(c))
            `CHK(ramp_time, ramp_tbl[c])
        end
        rd_reg(synth_cfg_pkg::OFS_RAMP, got);
        `CHK(got, 8'h18)
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
